// [logic/avm_detect.v]
// vector-magnitude change detector with APB register slave
`include "avm_regs.vh"

// What this block does
// [R01] event when distance from references exceeds threshold long enough to reach debounce count
// [R02] references come from internal copies or from initial-value registers
// [R03] internal references are never readable through any register
// [R04] latch off: flag follows debounced condition, set and cleared in real time
// [R05] latch on: flag holds until interrupt-cause register at 0x0C is read
// [R06] init source 0: capture current sample as references on enable
// [R07] init source 1: load references from initial-value registers
// [R08] hold 0: references replaced by current sample on each trigger
// [R09] hold 1: references kept from enable time, unchanged by triggers
// [R10] init source and hold both set: initial-value writes apply immediately
// [R11] function runs only while enable set; reset clears it; loads references on enable
// [R12] host keeps sample rate at or below 400 Hz
// [R13] clear mode 0: counter decrements by one on below-threshold sample
// [R14] clear mode 1: counter clears on below-threshold sample
// [R15] threshold is 13-bit unsigned, upper five bits in high register
// [R16] debounce count is 8 bits, one sample period per count
// [R17] initial X is signed 14-bit, upper six bits in high register
// [R18] low eight bits of initial X live at offset 0x64
// [R19] initial Y and Z are signed 14-bit, six-bit high plus eight-bit low
// [R20] evaluate once per sample; counter saturates at count; flag when reached
// [R21] compare squared distance against squared threshold, no square root
module avm_detect #(
  parameter AW = 12,
  parameter SW = 14
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // accelerometer output samples, one valid strobe per output-data-rate period
  input  wire          sample_valid,
  input  wire [SW-1:0] sample_x,
  input  wire [SW-1:0] sample_y,
  input  wire [SW-1:0] sample_z,
  // vector-change event flag
  output reg           event_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // map, index to byte address times four:
  //   0x0C  interrupt cause, read only, bit 1 shows the event flag
  //   0x5F  configuration: bit 6 latch, bit 5 init source, bit 4 hold, bit 3 enable
  //   0x60  threshold high: bit 7 clear mode, bits 4:0 threshold 12:8
  //   0x61  threshold low
  //   0x62  debounce count
  //   0x63  initial x high, six bits
  //   0x64  initial x low
  //   0x65  initial y high, six bits
  //   0x66  initial y low
  //   0x67  initial z high, six bits
  //   0x68  initial z low
  // any other index, or a misaligned address, answers with pslverr
  //
  // bus timing:
  //   every access gets exactly one answer cycle right after setup
  //   writes land at the access edge, read data is prepared at setup
  //
  // sample timing:
  //   a sample counts only once enable has been seen for a full cycle,
  //   so the references are settled before the first comparison
  //   the flag follows the sample edge by one register stage
  //
  // debounce:
  //   an above-threshold sample adds one, never past the programmed count
  //   reaching the count sets the condition; a count of zero sets it at once
  //   a below-threshold sample takes one off, or clears the count in clear mode
  //   the condition drops once the count falls short of the programmed value
  //   the rising edge of the condition is the trigger that moves references
  //
  // latch mode:
  //   a trigger sets the held flag; an interrupt-cause read clears it
  //   when both fall in one cycle the trigger wins, so no event is lost
  //
  // reference sources on enable:
  //   init source 0 takes the last sample received before enable
  //   init source 1 takes the three initial registers
  //   after a trigger, hold 0 takes the triggering sample itself
  //
  // limitations:
  //   the sample rate is the host's business, nothing here checks it
  //   references sit in flops with no address, so software cannot see them
  //   with hold and init source both set, references follow the initial
  //   registers every cycle, which costs nothing but a mux per axis
  //   the squared distance needs 30 bits, carried in 32; a sum under 30 bits would wrap

  reg  [7:0]    cfg_reg;
  reg  [7:0]    ths_hi_reg;
  reg  [7:0]    ths_lo_reg;
  reg  [7:0]    dbc_cnt_reg;
  reg  [7:0]    init_hi_reg [0:2];
  reg  [7:0]    init_lo_reg [0:2];
  reg  [SW-1:0] ref_reg     [0:2];
  reg  [SW-1:0] last_reg    [0:2];
  reg  [7:0]    dbc_reg;
  reg           cond_reg;
  reg           latch_reg;
  reg           en_d_reg;
  reg           trig;

  // apb decode
  wire [6:0]    idx;
  wire          aligned;
  wire          setup;
  wire          do_xfer;
  wire          do_write;
  wire          do_read;

  assign idx      = paddr[8:2];
  // upper address bits must be zero, otherwise an index would alias
  assign aligned  = (paddr[1:0] == 2'b00) && (paddr[AW-1:9] == {(AW-9){1'b0}});
  assign setup    = psel & ~penable;
  assign do_xfer  = psel & penable & pready;
  assign do_write = do_xfer & pwrite;
  assign do_read  = do_xfer & ~pwrite;

  // configuration fields
  wire          en;
  wire          latch_en;
  wire          init_src;
  wire          hold;
  wire          clr_mode;
  wire [12:0]   ths;

  assign en       = cfg_reg[`AVM_CFG_EN_BIT];                               // [R11]
  assign latch_en = cfg_reg[`AVM_CFG_LATCH_BIT];                            // [R05]
  assign init_src = cfg_reg[`AVM_CFG_INITSRC_BIT];                          // [R02]
  assign hold     = cfg_reg[`AVM_CFG_HOLD_BIT];                             // [R09]
  assign clr_mode = ths_hi_reg[`AVM_THS_CLRMODE_BIT];                       // [R14]
  assign ths      = {ths_hi_reg[4:0], ths_lo_reg};                          // [R15]

  reg           map_hit;
  reg  [7:0]    rd_byte;

  always @* begin
    map_hit = 1'b1;
    rd_byte = `AVM_RST_BYTE;
    case (idx)
      `AVM_IDX_INT_CAUSE: begin
        rd_byte = {6'h00, event_flag, 1'b0};                               // [R05]
      end
      `AVM_IDX_CFG: begin
        rd_byte = cfg_reg;
      end
      `AVM_IDX_THS_HI: begin
        rd_byte = ths_hi_reg;
      end
      `AVM_IDX_THS_LO: begin
        rd_byte = ths_lo_reg;
      end
      `AVM_IDX_DBC_CNT: begin
        rd_byte = dbc_cnt_reg;
      end
      `AVM_IDX_INITX_HI: begin
        rd_byte = init_hi_reg[0];                                          // [R17]
      end
      `AVM_IDX_INITX_LO: begin
        rd_byte = init_lo_reg[0];                                          // [R18]
      end
      `AVM_IDX_INITY_HI: begin
        rd_byte = init_hi_reg[1];                                          // [R19]
      end
      `AVM_IDX_INITY_LO: begin
        rd_byte = init_lo_reg[1];
      end
      `AVM_IDX_INITZ_HI: begin
        rd_byte = init_hi_reg[2];
      end
      `AVM_IDX_INITZ_LO: begin
        rd_byte = init_lo_reg[2];
      end
      // references have no address at all
      default: begin
        map_hit = 1'b0;                                                    // [R03]
      end
    endcase
    if (!aligned) begin
      map_hit = 1'b0;
    end
  end

  // no wait state: pready rises in the first access cycle, right after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `AVM_RST_WORD;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~map_hit;
      if (setup) begin
        prdata <= (map_hit && !pwrite) ? {24'h000000, rd_byte} : `AVM_RST_WORD;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= `AVM_RST_BYTE;
      ths_hi_reg  <= `AVM_RST_BYTE;
      ths_lo_reg  <= `AVM_RST_BYTE;
      dbc_cnt_reg <= `AVM_RST_BYTE;
    end else if (do_write && aligned) begin
      case (idx)
        `AVM_IDX_CFG: begin
          cfg_reg <= pwdata[7:0] & `AVM_CFG_MASK;
        end
        `AVM_IDX_THS_HI: begin
          ths_hi_reg <= pwdata[7:0] & `AVM_THS_HI_MASK;
        end
        `AVM_IDX_THS_LO: begin
          ths_lo_reg <= pwdata[7:0];
        end
        `AVM_IDX_DBC_CNT: begin
          dbc_cnt_reg <= pwdata[7:0];                                      // [R16]
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-axis initial values, references and squared differences

  wire [29:0] sq [0:2];

  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1) begin : g_axis
      wire [SW-1:0] cur  = (a == 0) ? sample_x : ((a == 1) ? sample_y : sample_z);
      wire [SW-1:0] init = {init_hi_reg[a][5:0], init_lo_reg[a]};
      wire [14:0]   diff = {cur[SW-1], cur} - {ref_reg[a][SW-1], ref_reg[a]};
      wire [14:0]   mag  = diff[14] ? (15'h0000 - diff) : diff;
      // each axis owns a high and a low byte, two indices apart per axis
      localparam [31:0] idx_hi = {25'h0000000, `AVM_IDX_INITX_HI} + 2 * a;
      assign sq[a] = mag * mag;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          init_hi_reg[a] <= `AVM_RST_BYTE;
          init_lo_reg[a] <= `AVM_RST_BYTE;
        end else if (do_write && aligned) begin
          if (idx == idx_hi[6:0]) begin
            init_hi_reg[a] <= pwdata[7:0] & `AVM_INIT_HI_MASK;             // [R19]
          end
          if (idx == idx_hi[6:0] + 7'h01) begin
            init_lo_reg[a] <= pwdata[7:0];
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          last_reg[a] <= {SW{1'b0}};
          ref_reg[a]  <= {SW{1'b0}};
        end else begin
          if (sample_valid) begin
            last_reg[a] <= cur;
          end
          if (en && !en_d_reg) begin
            ref_reg[a] <= init_src ? init : last_reg[a];                   // [R02] [R06] [R07]
          end else if (en && init_src && hold) begin
            // retune while running
            ref_reg[a] <= init;                                            // [R10]
          end else if (trig && !hold) begin
            ref_reg[a] <= cur;                                             // [R08] [R09]
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // magnitude compare and debounce

  wire [31:0] dist_sq;
  wire [25:0] ths_sq;
  wire        above;
  wire        run;

  // squared compare keeps the result exact without a root extractor
  assign dist_sq = {2'b00, sq[0]} + {2'b00, sq[1]} + {2'b00, sq[2]};
  assign ths_sq  = ths * ths;
  assign above   = dist_sq > {6'h00, ths_sq};                               // [R01] [R21]
  // the cycle right after enable is spent loading references
  assign run     = en && en_d_reg && sample_valid;                          // [R20]

  reg  [7:0]  dbc_next;
  reg         cond_next;

  always @* begin
    dbc_next  = dbc_reg;
    cond_next = cond_reg;
    trig      = 1'b0;
    if (run) begin
      if (above) begin
        dbc_next = (dbc_reg < dbc_cnt_reg) ? dbc_reg + 8'h01 : dbc_reg;   // [R20]
        if (dbc_next >= dbc_cnt_reg) begin
          cond_next = 1'b1;
          trig      = ~cond_reg;
        end
      end else begin
        if (clr_mode) begin
          dbc_next = 8'h00;                                                // [R14]
        end else if (dbc_reg != 8'h00) begin
          dbc_next = dbc_reg - 8'h01;                                      // [R13]
        end
        if (dbc_next < dbc_cnt_reg || dbc_cnt_reg == 8'h00) begin
          cond_next = 1'b0;
        end
      end
    end
  end

  wire cause_read = do_read && aligned && (idx == `AVM_IDX_INT_CAUSE);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_reg   <= 1'b0;
      dbc_reg    <= 8'h00;
      cond_reg   <= 1'b0;
      latch_reg  <= 1'b0;
    end else begin
      en_d_reg <= en;
      if (!en || !en_d_reg) begin
        // idle or just enabled: start from a clean count
        dbc_reg   <= 8'h00;
        cond_reg  <= 1'b0;
        latch_reg <= 1'b0;
      end else begin
        dbc_reg  <= dbc_next;
        cond_reg <= cond_next;
        // a new trigger wins over a read in the same cycle
        if (trig) begin
          latch_reg <= 1'b1;
        end else if (cause_read) begin
          latch_reg <= 1'b0;                                               // [R05]
        end
      end
    end
  end

  // output flag in its own process so it comes straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag <= 1'b0;
    end else if (!en || !en_d_reg) begin
      event_flag <= 1'b0;
    end else if (latch_en) begin
      // a trigger in the same cycle as the cause read keeps the flag up
      event_flag <= trig | (latch_reg & ~cause_read);                      // [R05]
    end else begin
      event_flag <= cond_next;                                             // [R04]
    end
  end

endmodule // avm_detect

// [logic/avm_regs.vh]
// register indices, field positions, reset values for the vector-magnitude detector
`ifndef AVM_REGS_VH
`define AVM_REGS_VH

// register indices; byte address is four times the index
`define AVM_IDX_INT_CAUSE   7'h0C
`define AVM_IDX_CFG         7'h5F
`define AVM_IDX_THS_HI      7'h60
`define AVM_IDX_THS_LO      7'h61
`define AVM_IDX_DBC_CNT     7'h62
`define AVM_IDX_INITX_HI    7'h63
`define AVM_IDX_INITX_LO    7'h64
`define AVM_IDX_INITY_HI    7'h65
`define AVM_IDX_INITY_LO    7'h66
`define AVM_IDX_INITZ_HI    7'h67
`define AVM_IDX_INITZ_LO    7'h68

// vector_event_config fields
`define AVM_CFG_LATCH_BIT   6
`define AVM_CFG_INITSRC_BIT 5
`define AVM_CFG_HOLD_BIT    4
`define AVM_CFG_EN_BIT      3
`define AVM_CFG_MASK        8'h78

// magnitude_threshold_high fields
`define AVM_THS_CLRMODE_BIT 7
`define AVM_THS_HI_MASK     8'h9F

// initial reference high registers keep six bits
`define AVM_INIT_HI_MASK    8'h3F

// interrupt-cause bit that shows the vector-change event
`define AVM_CAUSE_VEC_BIT   1

`define AVM_RST_BYTE        8'h00
`define AVM_RST_WORD        32'h0000_0000

`endif

// [tb/avm_detect_monitor.sv]
// concurrent checks on the detector ports, bound into the design
module avm_detect_monitor #(
  parameter AW = 12,
  parameter SW = 14
) (
  // clock and reset
  input wire          pclk,
  input wire          presetn,
  // apb
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  // samples and event
  input wire          sample_valid,
  input wire [SW-1:0] sample_x,
  input wire [SW-1:0] sample_y,
  input wire [SW-1:0] sample_z,
  input wire          event_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  //////////////////////////////////////////////////////////////////////////////
  property p_setup; psel && !penable |=> pready; endproperty
  a_setup: assert property (p_setup) else $error("no answer after setup");
  property p_ans; pready |-> $past(psel && !penable); endproperty
  a_ans: assert property (p_ans) else $error("answer without setup");
  property p_err0; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err0: assert property (p_err0) else $error("refused access returned data");
  property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  property p_cfg; rd && paddr == 12'h17C |-> (prdata[7:0] & 8'h87) == 8'h00; endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits set");
  property p_ths; rd && paddr == 12'h180 |-> prdata[6:5] == 2'b00; endproperty
  a_ths: assert property (p_ths) else $error("threshold high spare bits set");
  property p_init; rd && paddr inside {12'h18C, 12'h194, 12'h19C} |-> prdata[7:6] == 2'b00;
  endproperty
  a_init: assert property (p_init) else $error("initial high spare bits set");
  property p_rise; $rose(event_flag) |-> $past(sample_valid) || $past(sample_valid, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("flag rose without sample");
  // a fall needs a sample, a cause read or a config write behind it
  property p_fall; $fell(event_flag) |-> $past(sample_valid) || $past(sample_valid, 2)
    || $past(psel && penable) || $past(psel && penable, 2); endproperty
  a_fall: assert property (p_fall) else $error("flag fell without cause");
endmodule // avm_detect_monitor

bind avm_detect avm_detect_monitor #(.AW(AW), .SW(SW)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
  .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
  .event_flag(event_flag)
);

// [tb/avm_apb_host.sv]
// apb host model standing in for the processor on the register side
module avm_apb_host (
  // clock
  input  wire         pclk,
  // apb request
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0000_0000,
  // apb answer
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // entered just after a rising edge; the wait is bounded by the bench watchdog
  task automatic xfer(input logic w, input logic [6:0] i, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, i, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
endmodule // avm_apb_host

// [tb/accel_vector_magnitude_detect_tb_top.sv]
// self-checking testbench for the vector-magnitude change detector
module accel_vector_magnitude_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        sample_valid = 1'b0;
  logic [13:0] sx = 14'h0000;
  logic [13:0] sy = 14'h0000;
  logic [13:0] sz = 14'h0000;
  wire  [31:0] prdata, pwdata;
  wire  [11:0] paddr;
  wire         psel, penable, pwrite, pready, pslverr, event_flag;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic        er;
  always #5 pclk = ~pclk;
  avm_detect i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
    .sample_z(sz), .event_flag(event_flag));
  avm_apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    i_host.xfer(1'b1, i, d, rd, er);
  endtask
  task automatic rdc(input logic [6:0] i, input logic [7:0] exp);
    i_host.xfer(1'b0, i, 8'h00, rd, er);
    chk("rdata", {24'h00_0000, exp}, rd);
  endtask
  // one sample, spaced well apart so only one is in flight at a time
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic e);
    sample_valid <= 1'b1;
    sx <= x;
    sy <= y;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("event_flag", {31'h0, e}, {31'h0, event_flag});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [6:0] ia [6] = '{7'h5F, 7'h60, 7'h63, 7'h65, 7'h67, 7'h64};
    logic [7:0] ma [6] = '{8'h78, 8'h9F, 8'h3F, 8'h3F, 8'h3F, 8'hFF};
    for (int i = 'h5F; i <= 'h68; i++) rdc(i[6:0], 8'h00);
    rdc(7'h0C, 8'h00);
    i_host.xfer(1'b0, 7'h69, 8'h00, rd, er);
    chk("pslverr", 32'h1, {31'h0, er});
    foreach (ia[k]) begin
      wr(ia[k], 8'hFF);
      rdc(ia[k], ma[k]);
      wr(ia[k], 8'h00);
    end
  endtask
  task automatic t_run;
    wr(7'h61, 8'h32);
    wr(7'h64, 8'h64);
    wr(7'h5F, 8'h28);
    smp(14'd100, 14'd0, 1'b0);
    smp(14'd200, 14'd0, 1'b1);
    smp(14'd200, 14'd0, 1'b0);
    wr(7'h5F, 8'h00);
    wr(7'h5F, 8'h38);
    smp(14'd200, 14'd0, 1'b1);
    smp(14'd200, 14'd0, 1'b1);
    wr(7'h64, 8'hC8);
    smp(14'd200, 14'd0, 1'b0);
    smp(14'd200, 14'h3FCE, 1'b0);
    smp(14'd200, 14'h3FCD, 1'b1);
  endtask
  task automatic t_latch;
    wr(7'h5F, 8'h00);
    wr(7'h64, 8'h64);
    wr(7'h5F, 8'h78);
    smp(14'd200, 14'd0, 1'b1);
    smp(14'd100, 14'd0, 1'b1);
    rdc(7'h0C, 8'h02);
    @(posedge pclk);
    chk("event_flag", 32'h0, {31'h0, event_flag});
  endtask
  task automatic t_deb;
    wr(7'h5F, 8'h00);
    wr(7'h62, 8'h02);
    wr(7'h5F, 8'h38);
    smp(14'd200, 14'd0, 1'b0);
    smp(14'd200, 14'd0, 1'b1);
    smp(14'd200, 14'd0, 1'b1);
    smp(14'd100, 14'd0, 1'b0);
    smp(14'd200, 14'd0, 1'b1);
    wr(7'h60, 8'h80);
    smp(14'd100, 14'd0, 1'b0);
    smp(14'd200, 14'd0, 1'b0);
    smp(14'd200, 14'd0, 1'b1);
  endtask
  task automatic t_cap;
    wr(7'h5F, 8'h00);
    wr(7'h62, 8'h00);
    smp(14'd500, 14'd0, 1'b0);
    wr(7'h5F, 8'h18);
    smp(14'd500, 14'd0, 1'b0);
    smp(14'd0, 14'd0, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    $display("register test done");
    t_run();
    $display("realtime test done");
    t_latch();
    $display("latch test done");
    t_deb();
    $display("debounce test done");
    t_cap();
    $display("capture test done");
    end_sim();
  end
  // the whole run needs well under 2000 cycles
  initial begin
    #50us;
    n_errors++;
    end_sim();
  end
endmodule // accel_vector_magnitude_detect_tb_top
